// ===== include/efms_defines.vh
// Functional notes
// - pre-heat on below ON temperature, off above OFF temperature, when enabled
// - minimum-temperature function withholds load command until temperature exceeds set value
// - fuel level shown as percent, clamped between 0 and 110
// - calibration accepted only while config switch four is on
// - confirm on empty page stores float reading as zero point
// - confirm on full page stores full point and rescales fuel reading
// - pump and indicator on at 40 percent, off at 80 percent
// - reserve warning with buzzer at 10 percent; delayed lack alarm and stop at 5
// - all fuel thresholds are programmable settings
// - absent or open probe disables pump and hides fuel level
// - undervoltage with open-on-failure opens contactor and begins start cycle in the same clock
// - open-on-start option opens contactor at generator start instead
// - undervoltage clears only above minimum plus 30 volts
// - overvoltage starts generator; clears 15 volts below maximum
// - single-phase uses 20 volt and 10 volt hysteresis margins
// - threshold set beyond its programmable maximum disables that check
// - biphase monitors phases one and two; single-phase monitors phase one
// - optional phase-sequence check faults mains on wrong rotation, three-phase mode only
// - frequency limits min 35..55 Hz, max 51..75 Hz, each can be off
`ifndef EFMS_DEFINES_VH
`define EFMS_DEFINES_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define EFMS_CTRL_ADDR 8'h00
`define EFMS_TEMP_ADDR 8'h04
`define EFMS_FUEL_ADDR 8'h08
`define EFMS_VOLT_ADDR 8'h0C
`define EFMS_FREQ_ADDR 8'h10
`define EFMS_STAT_ADDR 8'h14
`define EFMS_CAL_ADDR 8'h18
`define EFMS_FDLY_ADDR 8'h1C

// ---------------------------------------------------------------
// control register bits
// ---------------------------------------------------------------
`define EFMS_C_PREHEAT 0
`define EFMS_C_MINTEMP 1
`define EFMS_C_ON_FAIL 2
`define EFMS_C_ON_START 3
`define EFMS_C_SEQ_EN 4
`define EFMS_C_MODE_LO 5
`define EFMS_C_MODE_HI 6
`define EFMS_C_BUZZ_EN 7
`define EFMS_C_CAL_EMPTY 8
`define EFMS_C_CAL_FULL 9

// mains configuration codes
`define EFMS_MODE_THREE 2'h0
`define EFMS_MODE_BI 2'h1
`define EFMS_MODE_SINGLE 2'h2

// ---------------------------------------------------------------
// reset values and limits
// ---------------------------------------------------------------
`define EFMS_CTRL_RST 32'h0000_0080
`define EFMS_TEMP_RST 32'h0000_3228
`define EFMS_FUEL_RST 32'h050A_2850
`define EFMS_VOLT_RST 32'h01B8_0140
`define EFMS_FREQ_RST 32'h0000_3F2D
`define EFMS_CAL_RST 32'h00FF_0000
`define EFMS_FDLY_RST 32'h0000_000A
`define EFMS_FUEL_MAX 8'h6E
`define EFMS_HYS_MIN3 10'h01E
`define EFMS_HYS_MAX3 10'h00F
`define EFMS_HYS_MIN1 10'h014
`define EFMS_HYS_MAX1 10'h00A
`define EFMS_VMIN_TOP 10'h190
`define EFMS_VMAX_TOP 10'h258
`define EFMS_VMIN_TOP1 10'h118
`define EFMS_VMAX_TOP1 10'h12C
`define EFMS_FMIN_TOP 8'h37
`define EFMS_FMAX_TOP 8'h4B
`define EFMS_FHYS 8'h01
`define EFMS_TICK_MS 1
`define EFMS_CLK_KHZ 200000

`endif

// ===== rtl/efms_fuel_scale.v
`timescale 1ns/1ps
// float reading to percent, clamped
module efms_fuel_scale #(
  parameter W = 8
) (
  input wire clk_i, // system clock
  input wire rst_i, // sync reset
  input wire en_i, // new sample strobe
  input wire [W-1:0] raw_i, // float reading
  input wire [W-1:0] empty_i, // zero point
  input wire [W-1:0] full_i, // full point
  output reg [7:0] pct_o, // fuel percent
  output reg valid_o // one-cycle result strobe
);
  `include "efms_defines.vh"

  reg [W-1:0] span;
  reg [W-1:0] ofs;
  reg [W+7:0] num;
  reg [W+7:0] quo;

  // ---------------------------------------------------------------
  // span and division
  // ---------------------------------------------------------------
  // combinational divide: slow but only once per sample
  always @* begin
    span = (full_i > empty_i) ? full_i - empty_i : {{(W-1){1'b0}}, 1'b1};
    ofs = (raw_i > empty_i) ? raw_i - empty_i : {W{1'b0}};
    num = ofs * 8'h64;
    quo = num / {8'h00, span};
  end

  // clamp at 110 percent
  always @(posedge clk_i) begin
    if (rst_i) begin
      pct_o <= 8'h00;
      valid_o <= 1'b0;
    end else begin
      valid_o <= en_i;
      if (en_i) begin
        if (quo > {{W{1'b0}}, `EFMS_FUEL_MAX})
          pct_o <= `EFMS_FUEL_MAX;
        else
          pct_o <= quo[7:0];
      end
    end
  end
endmodule // efms_fuel_scale

// ===== rtl/efms_supervisor.v
// Design decisions made here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// engine, fuel and mains supervisor with wishbone register port
module efms_supervisor #(
  parameter LACK_TICKS = 200000 // unused; delay tick is TICK, 200000 cycles (1 ms)
) (
  input wire clk_i, // system clock 200 MHz
  input wire rst_i, // sync reset, active high
  // wishbone classic slave
  input wire [7:0] wb_adr_i, // byte address
  input wire [31:0] wb_dat_i, // write data
  input wire [3:0] wb_sel_i, // byte lanes
  input wire wb_we_i, // write
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  // measurements
  input wire sample_i, // new measurement set
  input wire [7:0] temp_i, // engine temp, deg C
  input wire temp_ok_i, // temp probe present
  input wire [7:0] float_i, // float raw reading
  input wire probe_ok_i, // fuel probe present and closed
  input wire [9:0] v_l1_i, // phase 1 volts
  input wire [9:0] v_l2_i, // phase 2 volts
  input wire [9:0] v_l3_i, // phase 3 volts
  input wire [7:0] freq_i, // mains Hz
  input wire seq_ok_i, // phases arrive L1-L2-L3
  input wire cfg_sw4_i, // config switch 4
  input wire confirm_i, // confirm key pulse
  input wire gen_run_i, // generator running
  // outputs
  output reg preheat_o, // pre-heating command
  output reg load_en_o, // generator load command
  output reg pump_o, // fuel pump and indicator
  output reg reserve_o, // reserve warning
  output reg buzzer_o, // buzzer
  output reg lack_alarm_o, // lack-of-fuel alarm
  output reg gen_stop_o, // stop generator
  output reg mains_contactor_o, // mains contactor closed
  output reg gen_start_o, // begin start cycle
  output reg [7:0] fuel_pct_o, // displayed fuel percent
  output reg fuel_show_o // fuel display valid
);
  `include "efms_defines.vh"

  localparam [31:0] TICK = `EFMS_TICK_MS * `EFMS_CLK_KHZ;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [31:0] ctrl_reg;
  reg [31:0] temp_reg; // [7:0] on, [15:8] off, [23:16] min
  reg [31:0] fuel_reg; // stop, start, reserve, lack
  reg [31:0] volt_reg; // [9:0] min, [25:16] max
  reg [31:0] freq_reg; // [7:0] min, [15:8] max
  reg [31:0] cal_reg; // [7:0] empty, [23:16] full
  reg [31:0] fdly_reg; // lack delay ticks
  reg preheat_reg, minlow_reg, pump_reg, res_reg, lack_reg;
  reg uv_reg, ov_reg, uf_reg, of_reg;
  reg [15:0] lack_cnt_reg;
  reg [31:0] tick_cnt_reg;
  reg cal_empty_reg, cal_full_reg;
  reg samp_d_reg;

  wire [7:0] pct;
  wire pct_v;
  wire [1:0] mode = ctrl_reg[`EFMS_C_MODE_HI:`EFMS_C_MODE_LO];
  wire single = (mode == `EFMS_MODE_SINGLE);
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // byte-lane merge used by every writable register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // wishbone slave: one wait-free ack, next cycle
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= `EFMS_CTRL_RST;
      temp_reg <= `EFMS_TEMP_RST;
      fuel_reg <= `EFMS_FUEL_RST;
      volt_reg <= `EFMS_VOLT_RST;
      freq_reg <= `EFMS_FREQ_RST;
      fdly_reg <= `EFMS_FDLY_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i) begin
        if (wb_adr_i == `EFMS_CTRL_ADDR)
          ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == `EFMS_TEMP_ADDR)
          temp_reg <= merge(temp_reg, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == `EFMS_FUEL_ADDR)
          fuel_reg <= merge(fuel_reg, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == `EFMS_VOLT_ADDR)
          volt_reg <= merge(volt_reg, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == `EFMS_FREQ_ADDR)
          freq_reg <= merge(freq_reg, wb_dat_i, wb_sel_i);
        else if (wb_adr_i == `EFMS_FDLY_ADDR)
          fdly_reg <= merge(fdly_reg, wb_dat_i, wb_sel_i);
      end
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == `EFMS_CTRL_ADDR)
          wb_dat_o <= ctrl_reg;
        else if (wb_adr_i == `EFMS_TEMP_ADDR)
          wb_dat_o <= temp_reg;
        else if (wb_adr_i == `EFMS_FUEL_ADDR)
          wb_dat_o <= fuel_reg;
        else if (wb_adr_i == `EFMS_VOLT_ADDR)
          wb_dat_o <= volt_reg;
        else if (wb_adr_i == `EFMS_FREQ_ADDR)
          wb_dat_o <= freq_reg;
        else if (wb_adr_i == `EFMS_STAT_ADDR)
          wb_dat_o <= {16'h0000, fuel_pct_o, uv_reg, ov_reg, uf_reg,
            of_reg, lack_reg, res_reg, pump_reg, preheat_reg};
        else if (wb_adr_i == `EFMS_CAL_ADDR)
          wb_dat_o <= cal_reg;
        else if (wb_adr_i == `EFMS_FDLY_ADDR)
          wb_dat_o <= fdly_reg;
        else
          wb_dat_o <= 32'h0000_0000; // unmapped reads zero
      end
    end
  end

  // ---------------------------------------------------------------
  // fuel float calibration
  // ---------------------------------------------------------------
  // page selected in ctrl; confirm key only counts with switch 4 on
  always @(posedge clk_i) begin
    if (rst_i) begin
      cal_reg <= `EFMS_CAL_RST;
      cal_empty_reg <= 1'b0;
      cal_full_reg <= 1'b0;
    end else begin
      cal_empty_reg <= cfg_sw4_i & ctrl_reg[`EFMS_C_CAL_EMPTY];
      cal_full_reg <= cfg_sw4_i & ctrl_reg[`EFMS_C_CAL_FULL];
      if (confirm_i && cal_empty_reg)
        cal_reg[7:0] <= float_i;
      else if (confirm_i && cal_full_reg)
        cal_reg[23:16] <= float_i;
    end
  end

  efms_fuel_scale #(
    .W(8)
  ) u_scale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(sample_i),
    .raw_i(float_i),
    .empty_i(cal_reg[7:0]),
    .full_i(cal_reg[23:16]),
    .pct_o(pct),
    .valid_o(pct_v)
  );

  // ---------------------------------------------------------------
  // hysteresis evaluation, once per sample
  // ---------------------------------------------------------------
  reg [9:0] vlo, vhi, hmin, hmax, vmin, vmax, vtopmin, vtopmax;
  reg vmin_on, vmax_on, fmin_on, fmax_on;
  always @* begin
    vmin = volt_reg[9:0];
    vmax = volt_reg[25:16];
    hmin = single ? `EFMS_HYS_MIN1 : `EFMS_HYS_MIN3;
    hmax = single ? `EFMS_HYS_MAX1 : `EFMS_HYS_MAX3;
    vtopmin = single ? `EFMS_VMIN_TOP1 : `EFMS_VMIN_TOP;
    vtopmax = single ? `EFMS_VMAX_TOP1 : `EFMS_VMAX_TOP;
    vmin_on = (vmin <= vtopmin);
    vmax_on = (vmax <= vtopmax);
    fmin_on = (freq_reg[7:0] <= `EFMS_FMIN_TOP);
    fmax_on = (freq_reg[15:8] <= `EFMS_FMAX_TOP);
    // worst phase among the monitored inputs
    vlo = v_l1_i;
    vhi = v_l1_i;
    if (mode != `EFMS_MODE_SINGLE) begin
      if (v_l2_i < vlo) vlo = v_l2_i;
      if (v_l2_i > vhi) vhi = v_l2_i;
    end
    if (mode == `EFMS_MODE_THREE) begin
      if (v_l3_i < vlo) vlo = v_l3_i;
      if (v_l3_i > vhi) vhi = v_l3_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      uv_reg <= 1'b0;
      ov_reg <= 1'b0;
      uf_reg <= 1'b0;
      of_reg <= 1'b0;
      preheat_reg <= 1'b0;
      minlow_reg <= 1'b0;
      samp_d_reg <= 1'b0;
    end else begin
      samp_d_reg <= sample_i;
      if (sample_i) begin
        if (!vmin_on) uv_reg <= 1'b0;
        else if (vlo < vmin) uv_reg <= 1'b1;
        else if (vlo > vmin + hmin) uv_reg <= 1'b0;
        if (!vmax_on) ov_reg <= 1'b0;
        else if (vhi > vmax) ov_reg <= 1'b1;
        else if (vhi < vmax - hmax) ov_reg <= 1'b0;
        if (!fmin_on) uf_reg <= 1'b0;
        else if (freq_i < freq_reg[7:0]) uf_reg <= 1'b1;
        else if (freq_i > freq_reg[7:0] + `EFMS_FHYS) uf_reg <= 1'b0;
        if (!fmax_on) of_reg <= 1'b0;
        else if (freq_i > freq_reg[15:8]) of_reg <= 1'b1;
        else if (freq_i < freq_reg[15:8] - `EFMS_FHYS) of_reg <= 1'b0;
        // pre-heat off when running or above OFF level
        if (!ctrl_reg[`EFMS_C_PREHEAT] || !temp_ok_i || gen_run_i)
          preheat_reg <= 1'b0;
        else if (temp_i < temp_reg[7:0]) preheat_reg <= 1'b1;
        else if (temp_i > temp_reg[15:8]) preheat_reg <= 1'b0;
        if (!ctrl_reg[`EFMS_C_MINTEMP] || !temp_ok_i)
          minlow_reg <= 1'b0;
        else if (temp_i < temp_reg[23:16]) minlow_reg <= 1'b1;
        else if (temp_i > temp_reg[23:16]) minlow_reg <= 1'b0;
      end
    end
  end

  wire seq_bad = ctrl_reg[`EFMS_C_SEQ_EN] && (mode == `EFMS_MODE_THREE)
    && !seq_ok_i;
  wire mains_bad = uv_reg | ov_reg | uf_reg | of_reg | seq_bad;

  // ---------------------------------------------------------------
  // fuel thresholds; pct_v follows sample by one cycle
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      pump_reg <= 1'b0;
      res_reg <= 1'b0;
      lack_reg <= 1'b0;
    end else if (!probe_ok_i) begin
      pump_reg <= 1'b0;
      res_reg <= 1'b0;
    end else if (pct_v) begin
      if (pct <= fuel_reg[15:8]) pump_reg <= 1'b1;
      else if (pct >= fuel_reg[7:0]) pump_reg <= 1'b0;
      res_reg <= (pct <= fuel_reg[23:16]);
    end
  end

  // lack alarm after programmed delay; latches until reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      lack_cnt_reg <= 16'h0000;
      tick_cnt_reg <= 32'h0000_0000;
    end else if (!probe_ok_i || pct > fuel_reg[31:24]) begin
      lack_cnt_reg <= 16'h0000;
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick_cnt_reg >= TICK - 32'h1) begin
      tick_cnt_reg <= 32'h0000_0000;
      if (lack_cnt_reg < fdly_reg[15:0])
        lack_cnt_reg <= lack_cnt_reg + 16'h0001;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i)
      lack_reg <= 1'b0;
    else if (probe_ok_i && pct <= fuel_reg[31:24]
        && lack_cnt_reg >= fdly_reg[15:0])
      lack_reg <= 1'b1;
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      preheat_o <= 1'b0;
      load_en_o <= 1'b0;
      pump_o <= 1'b0;
      reserve_o <= 1'b0;
      buzzer_o <= 1'b0;
      lack_alarm_o <= 1'b0;
      gen_stop_o <= 1'b0;
      mains_contactor_o <= 1'b1;
      gen_start_o <= 1'b0;
      fuel_pct_o <= 8'h00;
      fuel_show_o <= 1'b0;
    end else begin
      preheat_o <= preheat_reg;
      load_en_o <= gen_run_i & ~minlow_reg & ~lack_reg;
      pump_o <= pump_reg & probe_ok_i;
      reserve_o <= res_reg;
      buzzer_o <= res_reg & ctrl_reg[`EFMS_C_BUZZ_EN];
      lack_alarm_o <= lack_reg;
      gen_stop_o <= lack_reg;
      gen_start_o <= mains_bad & ~lack_reg;
      // contactor opening point by option
      if (!mains_bad)
        mains_contactor_o <= 1'b1;
      else if (ctrl_reg[`EFMS_C_ON_FAIL])
        mains_contactor_o <= 1'b0;
      else if (ctrl_reg[`EFMS_C_ON_START] && gen_start_o)
        mains_contactor_o <= 1'b0;
      fuel_show_o <= probe_ok_i;
      fuel_pct_o <= probe_ok_i ? pct : 8'h00;
    end
  end
endmodule // efms_supervisor

// ===== test/efms_plant_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// generator start and stop relays, engine
// ------------------------------------------
module efms_plant_model #(
  parameter int RUN_DLY = 20 // cranking cycles
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic start_i, // start relay
  input wire logic stop_i, // stop relay
  output logic run_o // engine running
);
  int cnt;

  initial run_o = 1'b0;

  // engine fires once cnt reaches RUN_DLY with start relay on; count held while relay off; stop always wins
  always @(posedge clk_i) begin
    if (rst_i || stop_i) begin
      cnt <= 0;
      run_o <= 1'b0;
    end else if (start_i && cnt < RUN_DLY) begin
      cnt <= cnt + 1;
    end else if (start_i) begin
      run_o <= 1'b1;
    end
  end
endmodule // efms_plant_model

// ===== test/efms_monitor.sv
`timescale 1ns/1ps
`include "efms_defines.vh"
// ------------------------------------------
// bus and output timing checker
// ------------------------------------------
module efms_monitor (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write
  input wire wb_ack_o, // acknowledge
  input wire [31:0] wb_dat_o, // read data
  input wire sample_i, // sample strobe
  input wire probe_ok_i, // probe present
  input wire preheat_o, // pre-heat
  input wire pump_o, // pump
  input wire reserve_o, // reserve
  input wire lack_alarm_o, // lack alarm
  input wire [7:0] fuel_pct_o, // fuel percent
  input wire fuel_show_o // display valid
);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus answer: one cycle late, one cycle wide, data held between reads
  ack_resp_a: assert property (req |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  rd_hold_a: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved");
  // pump, reserve and pre-heat rise only in the sample pipeline; plus clamp, latch, probe-off checks
  fuel_clamp_a:
    assert property (fuel_show_o |-> fuel_pct_o <= `EFMS_FUEL_MAX)
    else $error("fuel percent over top");
  pump_rise_a:
    assert property ($rose(pump_o) |-> $past(sample_i, 3) ||
      $past(sample_i, 4)) else $error("pump rose off sample");
  reserve_rise_a:
    assert property ($rose(reserve_o) |-> $past(sample_i, 3) ||
      $past(sample_i, 4)) else $error("reserve rose off sample");
  preheat_rise_a:
    assert property ($rose(preheat_o) |-> $past(sample_i) ||
      $past(sample_i, 2)) else $error("preheat rose off sample");
  lack_latch_a: assert property (lack_alarm_o |=> lack_alarm_o)
    else $error("lack alarm dropped");
  probe_off_a:
    assert property (sample_i && !probe_ok_i |-> ##4 !pump_o &&
      !fuel_show_o) else $error("pump or display with no probe");

  pump_c: cover property ($rose(pump_o));
  reserve_c: cover property ($rose(reserve_o));
  preheat_c: cover property ($rose(preheat_o));
endmodule // efms_monitor

bind efms_supervisor efms_monitor mon (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_dat_o, .sample_i, .probe_ok_i,
  .preheat_o, .pump_o, .reserve_o, .lack_alarm_o, .fuel_pct_o,
  .fuel_show_o);

// ===== test/engine_fuel_mains_supervisor_tb_top.sv
`timescale 1ns/1ps
`include "efms_defines.vh"
// ------------------------------------------
// supervisor bench
// ------------------------------------------
module engine_fuel_mains_supervisor_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0, sample_i = 1'b0, temp_ok_i = 1'b1;
  logic probe_ok_i = 1'b1, seq_ok_i = 1'b1, cfg_sw4_i = 1'b0;
  logic confirm_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, temp_i = 8'h3C, float_i = 8'h00;
  logic [7:0] freq_i = 8'h32;
  logic [31:0] wb_dat_i = 32'h0, q;
  logic [3:0] wb_sel_i = 4'h0;
  logic [9:0] v_l1_i = 10'h190, v_l2_i = 10'h190, v_l3_i = 10'h190;
  wire [31:0] wb_dat_o;
  wire [7:0] fuel_pct_o;
  wire wb_ack_o, gen_run_i, preheat_o, load_en_o, pump_o, reserve_o;
  wire buzzer_o, lack_alarm_o, gen_stop_o, mains_contactor_o;
  wire gen_start_o, fuel_show_o;
  int fails = 0, num_checks = 0;

  efms_supervisor dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .sample_i,
    .temp_i, .temp_ok_i, .float_i, .probe_ok_i, .v_l1_i, .v_l2_i, .v_l3_i,
    .freq_i, .seq_ok_i, .cfg_sw4_i, .confirm_i, .gen_run_i, .preheat_o,
    .load_en_o, .pump_o, .reserve_o, .buzzer_o, .lack_alarm_o, .gen_stop_o,
    .mains_contactor_o, .gen_start_o, .fuel_pct_o, .fuel_show_o);
  efms_plant_model plant (.clk_i, .rst_i, .start_i(gen_start_o),
    .stop_i(gen_stop_o), .run_o(gen_run_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 40) fails++;
  endtask

  // sample pulse, then wait out the fuel pipeline
  task automatic smp();
    @(posedge clk_i);
    sample_i <= 1'b1;
    @(posedge clk_i);
    sample_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic conf();
    @(posedge clk_i);
    confirm_i <= 1'b1;
    @(posedge clk_i);
    confirm_i <= 1'b0;
  endtask

  task automatic t_reset();
    logic [7:0] adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18,
      8'h1C, 8'h20};
    logic [31:0] rv [8] = '{`EFMS_CTRL_RST, `EFMS_TEMP_RST, `EFMS_FUEL_RST,
      `EFMS_VOLT_RST, `EFMS_FREQ_RST, `EFMS_CAL_RST, `EFMS_FDLY_RST, 32'h0};
    chk("contactor", 32'h1, {31'h0, mains_contactor_o});
    chk("pump", 32'h0, {31'h0, pump_o});
    wb(8'h18, 1'b1, 32'h1234_5678);
    for (int i = 0; i < 8; i++) begin
      wb(adr[i], 1'b0, 32'h0);
      chk("reset reg", rv[i], q);
    end
    $display("test reset done");
  endtask

  task automatic t_preheat();
    logic [7:0] tv [4] = '{8'h1E, 8'h2D, 8'h37, 8'h2D};
    logic ev [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    wb(8'h00, 1'b1, 32'h0000_0081);
    for (int i = 0; i < 4; i++) begin
      temp_i <= tv[i];
      smp();
      chk("preheat", {31'h0, ev[i]}, {31'h0, preheat_o});
    end
    $display("test preheat done");
  endtask

  task automatic t_fuel();
    logic [7:0] fv [5] = '{8'hFA, 8'h82, 8'hAA, 8'hBE, 8'h6C};
    logic [7:0] pv [5] = '{8'h6E, 8'h1E, 8'h46, 8'h5A, 8'h08};
    logic [3:0] ov [5] = '{4'h8, 4'hC, 4'hC, 4'h8, 4'hF};
    float_i <= 8'h64;
    wb(8'h00, 1'b1, 32'h0000_0181);
    conf();
    wb(8'h18, 1'b0, 32'h0);
    chk("cal locked", `EFMS_CAL_RST, q);
    cfg_sw4_i <= 1'b1;
    conf();
    float_i <= 8'hC8;
    wb(8'h00, 1'b1, 32'h0000_0281);
    conf();
    wb(8'h18, 1'b0, 32'h0);
    chk("cal points", 32'h00C8_0064, q);
    cfg_sw4_i <= 1'b0;
    wb(8'h00, 1'b1, 32'h0000_0081);
    // show, pump, reserve, buzzer
    for (int i = 0; i < 5; i++) begin
      float_i <= fv[i];
      smp();
      chk("fuel pct", {24'h0, pv[i]}, {24'h0, fuel_pct_o});
      chk("fuel outs", {28'h0, ov[i]}, {28'h0, fuel_show_o, pump_o,
        reserve_o, buzzer_o});
    end
    float_i <= 8'hBE;
    smp();
    wb(8'h08, 1'b1, 32'h050A_3C50);
    float_i <= 8'h9B;
    smp();
    chk("pump level", 32'h1, {31'h0, pump_o});
    probe_ok_i <= 1'b0;
    smp();
    chk("no probe", 32'h0, {30'h0, pump_o, fuel_show_o});
    probe_ok_i <= 1'b1;
    $display("test fuel done");
  endtask

  // flags: undervolt, overvolt, underfreq, overfreq
  task automatic row(input logic [9:0] v1, input logic [9:0] v23,
      input logic [7:0] f, input logic [3:0] e);
    v_l1_i <= v1;
    v_l2_i <= v23;
    v_l3_i <= v23;
    freq_i <= f;
    smp();
    wb(8'h14, 1'b0, 32'h0);
    chk("mains flags", {28'h0, e}, {28'h0, q[7:4]});
  endtask

  task automatic t_mains();
    temp_i <= 8'h3C;
    wb(8'h00, 1'b1, 32'h0000_0085);
    row(10'h190, 10'h190, 8'h32, 4'h0);
    row(10'h12C, 10'h12C, 8'h32, 4'h8);
    chk("contactor", 32'h0, {31'h0, mains_contactor_o});
    row(10'h154, 10'h154, 8'h32, 4'h8);
    row(10'h168, 10'h168, 8'h32, 4'h0);
    row(10'h1C2, 10'h1C2, 8'h32, 4'h4);
    row(10'h1AE, 10'h1AE, 8'h32, 4'h4);
    row(10'h1A4, 10'h1A4, 8'h32, 4'h0);
    row(10'h190, 10'h190, 8'h28, 4'h2);
    row(10'h190, 10'h190, 8'h46, 4'h1);
    row(10'h190, 10'h190, 8'h32, 4'h0);
    wb(8'h00, 1'b1, 32'h0000_00C5);
    wb(8'h0C, 1'b1, 32'h00FA_00C8);
    row(10'h0E6, 10'h000, 8'h32, 4'h0);
    row(10'h0BE, 10'h000, 8'h32, 4'h8);
    row(10'h0D7, 10'h000, 8'h32, 4'h8);
    row(10'h0E1, 10'h000, 8'h32, 4'h0);
    row(10'h0FF, 10'h000, 8'h32, 4'h4);
    row(10'h0F5, 10'h000, 8'h32, 4'h4);
    row(10'h0EB, 10'h000, 8'h32, 4'h0);
    wb(8'h00, 1'b1, 32'h0000_0085);
    wb(8'h0C, 1'b1, 32'h01B8_0191);
    row(10'h064, 10'h064, 8'h32, 4'h0);
    $display("test mains done");
  endtask

  // load hold-off, phase sequence and contactor opening point
  task automatic t_gen();
    wb(8'h04, 1'b1, 32'h0037_3228);
    wb(8'h00, 1'b1, 32'h0000_0087);
    temp_i <= 8'h1E;
    smp();
    chk("load cold", 32'h0, {31'h0, load_en_o});
    temp_i <= 8'h3C;
    smp();
    chk("load warm", 32'h1, {31'h0, load_en_o});
    wb(8'h00, 1'b1, 32'h0000_0097);
    seq_ok_i <= 1'b0;
    smp();
    chk("seq start", 32'h1, {31'h0, gen_start_o});
    chk("seq open", 32'h0, {31'h0, mains_contactor_o});
    seq_ok_i <= 1'b1;
    wb(8'h00, 1'b1, 32'h0000_0098);
    chk("closed", 32'h1, {31'h0, mains_contactor_o});
    seq_ok_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("start first", 32'h3,
      {30'h0, gen_start_o, mains_contactor_o});
    @(posedge clk_i);
    #1;
    chk("open at start", 32'h0, {31'h0, mains_contactor_o});
    seq_ok_i <= 1'b1;
    $display("test gen done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog: the whole run needs well under this span
  initial begin
    #300000;
    fails++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_preheat();
    t_fuel();
    t_mains();
    t_gen();
    final_report();
  end
endmodule // engine_fuel_mains_supervisor_tb_top
